// >>> src/mes_pkg.sv
package mes_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] ZONE_STATUS_OFFSET = 8'h40;
    localparam logic [7:0] ANALOG_STATUS_OFFSET = 8'h41;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] ZONE_STATUS_USED = 8'h3F;
    localparam logic [7:0] ANALOG_STATUS_USED = 8'hFF;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // ------------------------------------------------------------------
    // Field positions in the zone and regulator register
    // ------------------------------------------------------------------
    localparam int ZONE_ONE_BIT = 0;
    localparam int ZONE_TWO_BIT = 1;
    localparam int ZONE_THREE_BIT = 2;
    localparam int ZONE_FOUR_BIT = 3;
    localparam int REG_ONE_HOT_BIT = 4;
    localparam int REG_TWO_HOT_BIT = 5;

    // ------------------------------------------------------------------
    // Serial link
    // ------------------------------------------------------------------
    localparam logic [6:0] SLAVE_ADDR_DEFAULT = 7'h2E;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] BIT_COUNT_RESET = 4'h0;

    typedef enum logic [1:0] {
        MES_SLEEP_S0,
        MES_SLEEP_S3,
        MES_SLEEP_S45
    } mes_sleep_e;

    typedef enum logic [2:0] {
        MES_LINK_IDLE,
        MES_LINK_ADDR,
        MES_LINK_CMD,
        MES_LINK_WDATA,
        MES_LINK_RDATA
    } mes_link_e;

endpackage

// >>> src/mes_top.sv
`timescale 1ns/100ps
// Behaviour
// - Monitored event sets and latches its status bit.
// - Any set status bit raises summary flag.
// - Alert driven while enabled and summary set.
// - Fixed-threshold processor-hot bits never reach summary.
// - Set bits stay until software clears them.
// - Clear refused while unmasked condition persists.
// - Masked condition lets bit be cleared.
// - ASF mode: read and write-one both clear.
// - Otherwise only write-one clears; reads harmless.
// - Optional sleep masks apply only when selected.
// - Zones in bits 0-3; zones 1-2 optionally masked.
// - Regulator-hot bits 4-5, sleep-masked; 7:6 reserved.
// - Analog input n sets bit n-1, sleep-masked.
module mes_top #(
    parameter logic [6:0] SLAVE_ADDR = mes_pkg::SLAVE_ADDR_DEFAULT
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic [3:0] zone_limit_error,
    input wire logic regulator_one_hot_input,
    input wire logic regulator_two_hot_input_n,
    input wire logic [7:0] analog_in_limit_error,
    input wire logic asf_mode,
    input wire logic alert_enable,
    input wire mes_pkg::mes_sleep_e sleep_state,
    input wire logic [1:0] zone_mask_s3,
    input wire logic [1:0] zone_mask_s45,
    output logic mgmt_error_summary,
    output logic alert_out,
    output logic alert_oe
);

    // ------------------------------------------------------------------
    // Pin synchronisers and edge detection
    // ------------------------------------------------------------------
    logic [1:0] scl_sync_reg;
    logic [1:0] sda_sync_reg;
    logic [1:0] hot_one_sync_reg;
    logic [1:0] hot_two_sync_reg;
    logic scl_prev_reg;
    logic sda_prev_reg;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            scl_sync_reg <= 2'h3;
            sda_sync_reg <= 2'h3;
            hot_one_sync_reg <= 2'h0;
            hot_two_sync_reg <= 2'h3;
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end else begin
            scl_sync_reg <= {scl_sync_reg[0], scl_in};
            sda_sync_reg <= {sda_sync_reg[0], sda_in};
            hot_one_sync_reg <= {hot_one_sync_reg[0], regulator_one_hot_input};
            hot_two_sync_reg <= {hot_two_sync_reg[0], regulator_two_hot_input_n};
            scl_prev_reg <= scl_sync_reg[1];
            sda_prev_reg <= sda_sync_reg[1];
        end
    end

    logic scl_s;
    logic sda_s;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    assign scl_s = scl_sync_reg[1];
    assign sda_s = sda_sync_reg[1];
    assign scl_rise = scl_s & ~scl_prev_reg;
    assign scl_fall = ~scl_s & scl_prev_reg;
    assign start_det = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
    assign stop_det = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;

    // ------------------------------------------------------------------
    // Serial slave: address, command, write data and read data bytes
    // ------------------------------------------------------------------
    mes_pkg::mes_link_e link_reg;
    logic [7:0] shift_reg;
    logic [3:0] bit_cnt_reg;
    logic ack_phase_reg;
    logic [7:0] cmd_reg;
    logic [7:0] wdata_reg;
    logic wr_pulse_reg;
    logic rd_pulse_reg;
    logic [7:0] read_mux;
    logic [7:0] zone_status_reg;
    logic [7:0] analog_status_reg;

    always_comb begin
        if (cmd_reg == mes_pkg::ZONE_STATUS_OFFSET) begin
            read_mux = zone_status_reg;
        end else if (cmd_reg == mes_pkg::ANALOG_STATUS_OFFSET) begin
            read_mux = analog_status_reg;
        end else begin
            read_mux = mes_pkg::UNMAPPED_READ;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            link_reg <= mes_pkg::MES_LINK_IDLE;
            shift_reg <= 8'h00;
            bit_cnt_reg <= mes_pkg::BIT_COUNT_RESET;
            ack_phase_reg <= 1'b0;
            cmd_reg <= 8'h00;
            wdata_reg <= 8'h00;
            wr_pulse_reg <= 1'b0;
            rd_pulse_reg <= 1'b0;
            sda_oe <= 1'b0;
        end else begin
            wr_pulse_reg <= 1'b0;
            rd_pulse_reg <= 1'b0;
            if (start_det) begin
                link_reg <= mes_pkg::MES_LINK_ADDR;
                bit_cnt_reg <= mes_pkg::BIT_COUNT_RESET;
                ack_phase_reg <= 1'b0;
                sda_oe <= 1'b0;
            end else if (stop_det) begin
                link_reg <= mes_pkg::MES_LINK_IDLE;
                ack_phase_reg <= 1'b0;
                sda_oe <= 1'b0;
            end else begin
                case (link_reg)
                    mes_pkg::MES_LINK_ADDR, mes_pkg::MES_LINK_CMD, mes_pkg::MES_LINK_WDATA: begin
                        if (scl_rise && !ack_phase_reg) begin
                            shift_reg <= {shift_reg[6:0], sda_s};
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end else if (scl_fall && !ack_phase_reg && bit_cnt_reg == mes_pkg::BITS_PER_BYTE) begin
                            if (link_reg != mes_pkg::MES_LINK_ADDR || shift_reg[7:1] == SLAVE_ADDR) begin
                                ack_phase_reg <= 1'b1;
                                sda_oe <= 1'b1;
                            end else begin
                                link_reg <= mes_pkg::MES_LINK_IDLE;
                            end
                            if (link_reg == mes_pkg::MES_LINK_CMD) begin
                                cmd_reg <= shift_reg;
                            end
                            if (link_reg == mes_pkg::MES_LINK_WDATA) begin
                                wdata_reg <= shift_reg;
                                wr_pulse_reg <= 1'b1;
                            end
                        end else if (scl_fall && ack_phase_reg) begin
                            ack_phase_reg <= 1'b0;
                            bit_cnt_reg <= mes_pkg::BIT_COUNT_RESET;
                            if (link_reg == mes_pkg::MES_LINK_ADDR && shift_reg[0]) begin
                                link_reg <= mes_pkg::MES_LINK_RDATA;
                                shift_reg <= read_mux;
                                sda_oe <= ~read_mux[7];
                                bit_cnt_reg <= 4'h1;
                                rd_pulse_reg <= 1'b1;
                            end else begin
                                sda_oe <= 1'b0;
                                link_reg <= (link_reg == mes_pkg::MES_LINK_ADDR) ?
                                    mes_pkg::MES_LINK_CMD : mes_pkg::MES_LINK_WDATA;
                            end
                        end
                    end
                    mes_pkg::MES_LINK_RDATA: begin
                        if (scl_fall && !ack_phase_reg) begin
                            if (bit_cnt_reg == mes_pkg::BIT_COUNT_RESET) begin
                                shift_reg <= read_mux;
                                sda_oe <= ~read_mux[7];
                                bit_cnt_reg <= 4'h1;
                                rd_pulse_reg <= 1'b1;
                            end else if (bit_cnt_reg == mes_pkg::BITS_PER_BYTE) begin
                                sda_oe <= 1'b0;
                                ack_phase_reg <= 1'b1;
                            end else begin
                                sda_oe <= ~shift_reg[6];
                                shift_reg <= {shift_reg[6:0], 1'b0};
                                bit_cnt_reg <= bit_cnt_reg + 4'h1;
                            end
                        end else if (scl_rise && ack_phase_reg) begin
                            ack_phase_reg <= 1'b0;
                            bit_cnt_reg <= mes_pkg::BIT_COUNT_RESET;
                            if (sda_s) begin
                                link_reg <= mes_pkg::MES_LINK_IDLE;
                            end
                        end
                    end
                    default: begin
                        sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Sleep masking and error conditions
    // ------------------------------------------------------------------
    logic in_s3;
    logic in_s45;
    logic deep_sleep;
    logic [1:0] zone_sleep_mask;
    logic [7:0] zone_mask;
    logic [7:0] analog_mask;
    logic [7:0] zone_cond;
    logic [7:0] zone_set;
    logic [7:0] analog_set;

    assign in_s3 = (sleep_state == mes_pkg::MES_SLEEP_S3);
    assign in_s45 = (sleep_state == mes_pkg::MES_SLEEP_S45);
    assign deep_sleep = in_s3 | in_s45;
    assign zone_sleep_mask = ({2{in_s3}} & zone_mask_s3) | ({2{in_s45}} & zone_mask_s45);

    always_comb begin
        zone_mask = 8'h00;
        zone_mask[mes_pkg::ZONE_ONE_BIT] = zone_sleep_mask[0];
        zone_mask[mes_pkg::ZONE_TWO_BIT] = zone_sleep_mask[1];
        zone_mask[mes_pkg::REG_ONE_HOT_BIT] = deep_sleep;
        zone_mask[mes_pkg::REG_TWO_HOT_BIT] = deep_sleep;
        zone_cond = 8'h00;
        zone_cond[mes_pkg::ZONE_FOUR_BIT:mes_pkg::ZONE_ONE_BIT] = zone_limit_error;
        zone_cond[mes_pkg::REG_ONE_HOT_BIT] = hot_one_sync_reg[1];
        zone_cond[mes_pkg::REG_TWO_HOT_BIT] = ~hot_two_sync_reg[1];
    end

    assign analog_mask = {8{deep_sleep}};
    assign zone_set = zone_cond & ~zone_mask & mes_pkg::ZONE_STATUS_USED;
    assign analog_set = analog_in_limit_error & ~analog_mask;

    // ------------------------------------------------------------------
    // Status latches with write-one and read clears
    // ------------------------------------------------------------------
    logic zone_sel;
    logic analog_sel;
    logic [7:0] wr_clear;
    logic [7:0] rd_clear;
    logic [7:0] zone_status_next;
    logic [7:0] analog_status_next;

    assign zone_sel = (cmd_reg == mes_pkg::ZONE_STATUS_OFFSET);
    assign analog_sel = (cmd_reg == mes_pkg::ANALOG_STATUS_OFFSET);
    assign wr_clear = {8{wr_pulse_reg}} & wdata_reg;
    assign rd_clear = {8{rd_pulse_reg & asf_mode}};

    // Set terms are ORed last so a fresh or persisting condition beats any clear.
    assign zone_status_next = ((zone_status_reg & ~({8{zone_sel}} & (wr_clear | rd_clear))) | zone_set)
        & mes_pkg::ZONE_STATUS_USED;
    assign analog_status_next = (analog_status_reg & ~({8{analog_sel}} & (wr_clear | rd_clear)))
        | analog_set;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            zone_status_reg <= mes_pkg::STATUS_RESET;
            analog_status_reg <= mes_pkg::STATUS_RESET;
        end else begin
            zone_status_reg <= zone_status_next;
            analog_status_reg <= analog_status_next;
        end
    end

    // ------------------------------------------------------------------
    // Summary flag and alert
    // ------------------------------------------------------------------
    // Processor-hot fixed-threshold bits are not part of this bank, so they never enter the OR.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            mgmt_error_summary <= 1'b0;
            alert_oe <= 1'b0;
            alert_out <= 1'b0;
            sda_out <= 1'b0;
        end else begin
            mgmt_error_summary <= |{zone_status_next, analog_status_next};
            alert_oe <= alert_enable & (|{zone_status_next, analog_status_next});
            alert_out <= 1'b0;
            sda_out <= 1'b0;
        end
    end

endmodule

// >>> verif/mes_top_chk.sv
`timescale 1ns/100ps
module mes_top_chk (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic scl_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic [3:0] zone_limit_error,
    input wire logic regulator_one_hot_input,
    input wire logic regulator_two_hot_input_n,
    input wire logic [7:0] analog_in_limit_error,
    input wire logic alert_enable,
    input wire mes_pkg::mes_sleep_e sleep_state,
    input wire logic mgmt_error_summary,
    input wire logic alert_out,
    input wire logic alert_oe
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);
    chk_zone_sets_summary: assert property (
        zone_limit_error[3:2] != 2'h0 |=> mgmt_error_summary) else $error("zone error left summary low");
    chk_analog_sets_awake: assert property (
        analog_in_limit_error != 8'h00 && sleep_state == mes_pkg::MES_SLEEP_S0 |=> mgmt_error_summary)
        else $error("analog error left summary low");
    chk_regulator_hot_sets: assert property (
        ((regulator_one_hot_input || !regulator_two_hot_input_n) && sleep_state == mes_pkg::MES_SLEEP_S0)[*4]
        |-> mgmt_error_summary) else $error("regulator hot left summary low");
    chk_alert_tracks_summary: assert property (
        alert_oe == (mgmt_error_summary && $past(alert_enable))) else $error("alert mismatch");
    chk_sleep_masks_events: assert property (
        (sleep_state == mes_pkg::MES_SLEEP_S3 && zone_limit_error == 4'h0 && !mgmt_error_summary)[*3]
        |=> !mgmt_error_summary) else $error("masked event raised summary");
    chk_clear_by_host: assert property (
        $fell(mgmt_error_summary) |-> !$past(scl_in, 3)) else $error("summary fell outside a transfer");
    chk_ack_clock_low: assert property (
        $changed(sda_oe) |-> !$past(scl_in, 2)) else $error("data pin moved with clock high");
    chk_open_drain_low: assert property (
        !sda_out && !alert_out) else $error("open drain pin driven high");
    cover property ($rose(alert_oe));
    cover property ($fell(mgmt_error_summary));
    cover property ($rose(sda_oe));
endmodule
bind mes_top mes_top_chk u_mes_top_chk (
    .core_clk(core_clk),
    .rstn(rstn),
    .scl_in(scl_in),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .zone_limit_error(zone_limit_error),
    .regulator_one_hot_input(regulator_one_hot_input),
    .regulator_two_hot_input_n(regulator_two_hot_input_n),
    .analog_in_limit_error(analog_in_limit_error),
    .alert_enable(alert_enable),
    .sleep_state(sleep_state),
    .mgmt_error_summary(mgmt_error_summary),
    .alert_out(alert_out),
    .alert_oe(alert_oe)
);

// >>> verif/mes_bmc_model.sv
`timescale 1ns/100ps
module mes_bmc_model #(
    parameter time Q = 40ns
) (
    output logic scl,
    output logic sda_m,
    input wire logic sda
);
    // Master side of the link; a released data line reads high through the pull-up.
    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
    end
    task automatic bit_io(input logic b, output logic r);
        sda_m = b;
        #Q scl = 1'b1;
        #Q r = sda;
        #Q scl = 1'b0;
        #Q;
    endtask
    // Start when lvl is high, stop when lvl is low.
    task automatic cond(input logic lvl);
        sda_m = lvl;
        #Q scl = 1'b1;
        #Q sda_m = ~lvl;
        #Q scl = ~lvl;
        #Q;
    endtask
    task automatic xfer(input logic [7:0] d, output logic [7:0] r, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r[i]);
        end
        bit_io(1'b1, ack);
    endtask
    task automatic frame(input logic [6:0] a, input logic [7:0] cmd, input logic [7:0] d, input logic rd,
                         output logic [7:0] q, output logic ok);
        logic [2:0] k;
        logic [7:0] x;
        cond(1'b1);
        xfer({a, 1'b0}, x, k[0]);
        xfer(cmd, x, k[1]);
        if (rd) begin
            cond(1'b1);
            xfer({a, 1'b1}, x, k[2]);
            xfer(8'hFF, q, x[0]);
        end else begin
            xfer(d, q, k[2]);
        end
        cond(1'b0);
        ok = (k == 3'b000);
    endtask
endmodule

// >>> verif/mes_top_tb_top.sv
`timescale 1ns/100ps
module mes_top_tb_top;
    localparam logic [7:0] ZS = mes_pkg::ZONE_STATUS_OFFSET;
    localparam logic [7:0] AS = mes_pkg::ANALOG_STATUS_OFFSET;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic r1 = 1'b0;
    logic r2_n = 1'b1;
    logic asf = 1'b0;
    logic aen = 1'b1;
    logic [3:0] zone = 4'h0;
    logic [7:0] an = 8'h00;
    logic [1:0] ms3 = 2'h0;
    logic [1:0] ms45 = 2'h0;
    mes_pkg::mes_sleep_e slp = mes_pkg::MES_SLEEP_S0;
    logic scl, sda_m, sda_oe, summ, alert_oe;
    int fails = 0;
    int n_compared = 0;
    wire logic sda = sda_m & ~sda_oe;
    mes_bmc_model u_mes_bmc_model (.scl(scl), .sda_m(sda_m), .sda(sda));
    mes_top u_mes_top (
        .core_clk(core_clk), .rstn(rstn), .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe(sda_oe),
        .zone_limit_error(zone), .regulator_one_hot_input(r1), .regulator_two_hot_input_n(r2_n),
        .analog_in_limit_error(an), .asf_mode(asf), .alert_enable(aen), .sleep_state(slp), .zone_mask_s3(ms3),
        .zone_mask_s45(ms45), .mgmt_error_summary(summ), .alert_out(), .alert_oe(alert_oe)
    );
    initial begin
        forever #10 core_clk = ~core_clk;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // A read compares the byte returned with d.
    task automatic bus(input logic [7:0] cmd, input logic [7:0] d, input logic rd);
        logic [7:0] q;
        logic ok;
        u_mes_bmc_model.frame(mes_pkg::SLAVE_ADDR_DEFAULT, cmd, d, rd, q, ok);
        chk("ack", 8'h01, {7'h0, ok});
        if (rd) begin
            chk("read", d, q);
        end
    endtask
    task automatic t_latch();
        bus(ZS, mes_pkg::STATUS_RESET, 1'b1);
        bus(AS, mes_pkg::STATUS_RESET, 1'b1);
        zone[2] = 1'b1;
        cyc(1);
        zone[2] = 1'b0;
        cyc(2);
        chk("alert", 8'h01, {7'h0, alert_oe});
        bus(ZS, 8'h04, 1'b1);
        bus(ZS, 8'h04, 1'b1);
        bus(ZS, 8'hC0, 1'b0);
        bus(ZS, 8'h04, 1'b1);
        bus(ZS, 8'h04, 1'b0);
        bus(ZS, 8'h00, 1'b1);
        chk("summary", 8'h00, {7'h0, summ});
        $display("test latch done");
    endtask
    task automatic t_refuse();
        an[7] = 1'b1;
        cyc(2);
        bus(AS, 8'hFF, 1'b0);
        bus(AS, 8'h80, 1'b1);
        an[7] = 1'b0;
        bus(AS, 8'h80, 1'b0);
        bus(AS, 8'h00, 1'b1);
        $display("test refuse done");
    endtask
    task automatic t_mask();
        slp = mes_pkg::MES_SLEEP_S3;
        ms3 = 2'b10;
        an = 8'hFF;
        r1 = 1'b1;
        r2_n = 1'b0;
        cyc(8);
        bus(AS, 8'h00, 1'b1);
        bus(ZS, 8'h00, 1'b1);
        zone[1:0] = 2'b11;
        cyc(2);
        bus(ZS, 8'h01, 1'b1);
        slp = mes_pkg::MES_SLEEP_S0;
        cyc(4);
        bus(ZS, 8'h33, 1'b1);
        slp = mes_pkg::MES_SLEEP_S3;
        bus(ZS, 8'hFF, 1'b0);
        bus(AS, 8'hFF, 1'b0);
        bus(ZS, 8'h01, 1'b1);
        bus(AS, 8'h00, 1'b1);
        slp = mes_pkg::MES_SLEEP_S45;
        ms45 = 2'b01;
        bus(ZS, 8'hFF, 1'b0);
        bus(ZS, 8'h02, 1'b1);
        zone = 4'h0;
        an = 8'h00;
        r1 = 1'b0;
        r2_n = 1'b1;
        cyc(4);
        slp = mes_pkg::MES_SLEEP_S0;
        cyc(4);
        bus(ZS, 8'hFF, 1'b0);
        chk("summary", 8'h00, {7'h0, summ});
        $display("test mask done");
    endtask
    task automatic t_asf();
        asf = 1'b1;
        aen = 1'b0;
        an[0] = 1'b1;
        cyc(1);
        an[0] = 1'b0;
        cyc(2);
        chk("alert", 8'h00, {7'h0, alert_oe});
        bus(AS, 8'h01, 1'b1);
        bus(AS, 8'h00, 1'b1);
        bus(8'h42, mes_pkg::UNMAPPED_READ, 1'b1);
        asf = 1'b0;
        $display("test asf done");
    endtask
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        #1ms;
        fails++;
        summarize();
    end
    initial begin
        cyc(10);
        rstn = 1'b1;
        cyc(2);
        t_latch();
        t_refuse();
        t_mask();
        t_asf();
        summarize();
    end
endmodule
